// ===== rtl/osp_pkg.sv
// osp_pkg: shared types and constants for the sync pin mode block
// assumes a single 100 MHz core clock domain
package osp_pkg;

  // ------------------------------------------------------------------
  // mode codes of the four-bit mode field
  // ------------------------------------------------------------------
  localparam logic [3:0] OSP_MODE_SAMPLE_OUT = 4'h4;
  localparam logic [3:0] OSP_MODE_SAMPLE_RTC = 4'h5;
  localparam logic [3:0] OSP_MODE_SLAVE_EXP = 4'h6;
  localparam logic [3:0] OSP_MODE_MASTER_EXP = 4'h7;
  localparam logic [3:0] OSP_MODE_RESET = 4'h0;
  localparam logic [7:0] OSP_SYNC_CTRL_OFFSET = 8'h10;

  // ------------------------------------------------------------------
  // timing: sample pulse width on the master output
  // ------------------------------------------------------------------
  localparam int OSP_CLK_PERIOD_NS = 10;
  localparam int OSP_PULSE_NS = 100;
  localparam int OSP_PULSE_CYC_I = (OSP_PULSE_NS + OSP_CLK_PERIOD_NS - 1)
                                   / OSP_CLK_PERIOD_NS;
  localparam logic [3:0] OSP_PULSE_CYC = 4'(OSP_PULSE_CYC_I);

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic o;
    logic oe;
  } osp_pin_s;

  typedef struct packed {
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic sync_a_lvl;
    logic sync_b_lvl;
    logic trig_pend;
    logic lf_pend;
    logic [3:0] pulse_cnt;
    osp_pin_s pin_a;
    osp_pin_s pin_b;
    logic sample_tick;
    logic exp_tick;
  } osp_state_s;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  // pin b idles high (pull-up, clock idle); seeding its synchroniser
  // high avoids a false rising edge straight after reset
  localparam osp_state_s OSP_STATE_RST = '{
    sync_b: 3'h7,
    sync_b_lvl: 1'b1,
    default: '0
  };

endpackage : osp_pkg

// ===== rtl/osp_sync_pins.sv
// osp_sync_pins: mode-dependent drive of the two synchronisation pins
// assumes the sequencer supplies internal ticks and exposure slot info,
// and that the mode field is held stable by the register block outside
//
// Summary of operation
// RL1: four-bit mode field selects pin functions
// RL2: mode 0100 drives pin a as sample output
// RL3: mode 0100 mux pin low on slots
// RL4: mode 0100 mux pin tristate without slots
// RL5: mode 0100 timing from internal oscillator
// RL6: mode 0101 sample out, pin b clock input
// RL7: mode 0101 exposures timed from external clock
// RL8: mode 0110 pin a is trigger input
// RL9: outside source supplies triggers in 0110
// RL10: mode 0110 all timing from trigger
// RL11: modes 0110/0111 mux pin high on slots
// RL12: modes 0110/0111 mux tristate without slots
// RL13: mode 0111 drives pin a as exposure output
// RL14: mode 0111 timing generated internally
// RL15: slots a-c map to muxed emitters 4-6
`timescale 1ns/1ps
`default_nettype none

module osp_sync_pins
  import osp_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_sync_mode,
  input wire logic i_int_sample_tick,
  input wire logic i_int_exp_tick,
  input wire logic [2:0] i_slot_abc_enabled,
  input wire logic [2:0] i_slot_abc_active,
  input wire logic i_sync_pin_a_in,
  input wire logic i_sync_pin_b_in,
  output logic o_sync_pin_a_out,
  output logic o_sync_pin_a_oe,
  output logic o_sync_pin_b_out,
  output logic o_sync_pin_b_oe,
  output logic o_sample_tick,
  output logic o_exp_tick
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  osp_state_s state_q;
  osp_state_s state_d;

  logic any_slot_en;
  logic in_muxed_exp;
  logic a_rise;
  logic b_rise;
  logic a_stable;
  logic b_stable;
  logic [1:0][2:0] sync_stg;
  logic [1:0] sync_lvl;
  logic [1:0] pin_stable;
  logic [1:0] pin_rise;

  // RL15 slot mapping
  // slots a, b, c expose through the external mux onto emitters 4-6
  assign any_slot_en = |i_slot_abc_enabled;
  assign in_muxed_exp = |(i_slot_abc_enabled & i_slot_abc_active);

  // index 0 is pin a, index 1 is pin b
  assign sync_stg = {state_q.sync_b, state_q.sync_a};
  assign sync_lvl = {state_q.sync_b_lvl, state_q.sync_a_lvl};

  // ------------------------------------------------------------------
  // pin input edge detect
  // ------------------------------------------------------------------
  // a level change counts only once stages two and three agree
  for (genvar gi = 0; gi < 2; gi++) begin : g_pin_edge
    assign pin_stable[gi] = sync_stg[gi][2] == sync_stg[gi][1];
    assign pin_rise[gi] = pin_stable[gi] && sync_stg[gi][1] && !sync_lvl[gi];
  end

  assign a_stable = pin_stable[0];
  assign b_stable = pin_stable[1];
  assign a_rise = pin_rise[0];
  assign b_rise = pin_rise[1];

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.sync_a = {state_q.sync_a[1:0], i_sync_pin_a_in};
    state_d.sync_b = {state_q.sync_b[1:0], i_sync_pin_b_in};
    if (a_stable) begin
      state_d.sync_a_lvl = state_q.sync_a[1];
    end
    if (b_stable) begin
      state_d.sync_b_lvl = state_q.sync_b[1];
    end
    state_d.sample_tick = 1'b0;
    state_d.exp_tick = 1'b0;
    state_d.trig_pend = a_rise;
    state_d.lf_pend = b_rise;
    if (state_q.pulse_cnt != 4'h0) begin
      state_d.pulse_cnt = state_q.pulse_cnt - 4'h1;
    end
    state_d.pin_a = '{o: 1'b0, oe: 1'b0};
    state_d.pin_b = '{o: 1'b0, oe: 1'b0};

    // RL1 mode decode
    unique case (i_sync_mode)
      OSP_MODE_SAMPLE_OUT: begin
        // RL5 internal oscillator
        state_d.sample_tick = i_int_sample_tick;
        state_d.exp_tick = i_int_exp_tick;
        // RL2 sample output
        if (i_int_sample_tick) begin
          state_d.pulse_cnt = OSP_PULSE_CYC;
        end
        state_d.pin_a = '{o: state_q.pulse_cnt != 4'h0, oe: 1'b1};
        // RL3 mux low active
        // RL4 tristate otherwise
        state_d.pin_b = '{o: !in_muxed_exp, oe: any_slot_en};
      end
      OSP_MODE_SAMPLE_RTC: begin
        // RL6 sample output
        state_d.sample_tick = i_int_sample_tick;
        if (i_int_sample_tick) begin
          state_d.pulse_cnt = OSP_PULSE_CYC;
        end
        state_d.pin_a = '{o: state_q.pulse_cnt != 4'h0, oe: 1'b1};
        // RL7 external clock exposures
        // one exposure step per rising edge of the low-frequency clock
        state_d.exp_tick = state_q.lf_pend;
      end
      OSP_MODE_SLAVE_EXP: begin
        // RL8 RL9 trigger input
        // RL10 timing from trigger
        state_d.sample_tick = state_q.trig_pend;
        state_d.exp_tick = state_q.trig_pend;
        // RL11 mux high active
        // RL12 tristate otherwise
        state_d.pin_b = '{o: in_muxed_exp, oe: any_slot_en};
      end
      OSP_MODE_MASTER_EXP: begin
        // RL14 internal timing
        state_d.sample_tick = i_int_sample_tick;
        state_d.exp_tick = i_int_exp_tick;
        // RL13 exposure output
        if (i_int_exp_tick) begin
          state_d.pulse_cnt = OSP_PULSE_CYC;
        end
        state_d.pin_a = '{o: state_q.pulse_cnt != 4'h0, oe: 1'b1};
        // RL11 mux high active
        // RL12 tristate otherwise
        state_d.pin_b = '{o: in_muxed_exp, oe: any_slot_en};
      end
      default: begin
        // other modes belong to neighbouring logic; pins released
        state_d.pulse_cnt = 4'h0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_q <= OSP_STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_sync_pin_a_out = state_q.pin_a.o;
  assign o_sync_pin_a_oe = state_q.pin_a.oe;
  assign o_sync_pin_b_out = state_q.pin_b.o;
  assign o_sync_pin_b_oe = state_q.pin_b.oe;
  assign o_sample_tick = state_q.sample_tick;
  assign o_exp_tick = state_q.exp_tick;

endmodule // osp_sync_pins

`default_nettype wire

// ===== testbench/osp_far_side.sv
// far side: trigger source on pin a, pulled-up mux line on pin b
// assumes the bench drives trigger and low-frequency clock levels
`timescale 1ns/1ps
`default_nettype none
module osp_far_side (
  input wire logic i_a_out, i_a_oe, i_b_out, i_b_oe, i_trig, i_lf,
  output logic o_a, o_b
);
  // trigger drives pin a when released
  assign o_a = i_a_oe ? i_a_out : i_trig;
  // clock idles at the pull-up level
  assign o_b = i_b_oe ? i_b_out : i_lf;
endmodule // osp_far_side
`default_nettype wire

// ===== testbench/osp_sync_pins_monitor.sv
// port checks for osp_sync_pins
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module osp_sync_pins_monitor
  import osp_pkg::*;
(
  input wire logic i_core_clk, i_rst_b,
  input wire logic [3:0] i_sync_mode,
  input wire logic i_int_sample_tick, i_int_exp_tick,
  input wire logic [2:0] i_slot_abc_enabled, i_slot_abc_active,
  input wire logic i_sync_pin_a_in, i_sync_pin_b_in,
  input wire logic o_sync_pin_a_out, o_sync_pin_a_oe,
  input wire logic o_sync_pin_b_out, o_sync_pin_b_oe,
  input wire logic o_sample_tick, o_exp_tick
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic m4 = i_sync_mode == OSP_MODE_SAMPLE_OUT;
  wire logic m5 = i_sync_mode == OSP_MODE_SAMPLE_RTC;
  wire logic m6 = i_sync_mode == OSP_MODE_SLAVE_EXP;
  wire logic m7 = i_sync_mode == OSP_MODE_MASTER_EXP;
  wire logic en = |i_slot_abc_enabled;
  wire logic ac = |(i_slot_abc_enabled & i_slot_abc_active);
  off_mode_a: assert property (!(m4 | m5 | m6 | m7) |=>
    !o_sync_pin_a_oe && !o_sync_pin_b_oe) else $error("pin driven");
  mux_low_a: assert property (m4 && en |=> o_sync_pin_b_oe &&
    o_sync_pin_b_out == !$past(ac)) else $error("mux low");
  mux_high_a: assert property ((m6 | m7) && en |=>
    o_sync_pin_b_oe && o_sync_pin_b_out == $past(ac)) else $error("mux hi");
  mux_off_a: assert property (m5 || (m4 | m6 | m7) && !en |=>
    !o_sync_pin_b_oe) else $error("mux oe");
  samp_pulse_a: assert property ((m4 | m5) && i_int_sample_tick |=>
    o_sample_tick ##1 o_sync_pin_a_out[*8]) else $error("sample out");
  pin_a_dir_a: assert property ((m4 | m5 | m6 | m7) |=>
    o_sync_pin_a_oe != $past(m6)) else $error("pin a dir");
  trig_in_a: assert property (m6 && $rose(i_sync_pin_a_in) |->
    ##[2:8] o_sample_tick) else $error("trigger");
  exp_out_a: assert property (m7 && i_int_exp_tick |=>
    o_exp_tick ##1 o_sync_pin_a_out) else $error("exp out");
  cover property (m6 && o_sample_tick);
  cover property (m5 && o_exp_tick);
  cover property (m4 && o_sync_pin_b_oe && !o_sync_pin_b_out);
endmodule // osp_sync_pins_monitor
bind osp_sync_pins osp_sync_pins_monitor osp_sync_pins_monitor_inst (.*);
`default_nettype wire

// ===== testbench/osp_sync_pins_tb_top.sv
// directed scenarios for osp_sync_pins
// assumes osp_far_side resolves both pin wires
`timescale 1ns/1ps
`default_nettype none
module osp_sync_pins_tb_top;
  import osp_pkg::*;
  logic clk = 0, rb = 0, ist = 0, iet = 0, trig = 0, lf = 1;
  logic [3:0] md = OSP_MODE_RESET;
  logic [2:0] en = 3'h0, ac = 3'h0;
  logic pa, pb, ao, aoe, bo, boe, st, et;
  int error_cnt = 0, checks_done = 0;
  osp_sync_pins osp_sync_pins_inst (.i_core_clk(clk), .i_rst_b(rb),
    .i_sync_mode(md), .i_int_sample_tick(ist), .i_int_exp_tick(iet),
    .i_slot_abc_enabled(en), .i_slot_abc_active(ac),
    .i_sync_pin_a_in(pa), .i_sync_pin_b_in(pb), .o_sync_pin_a_out(ao),
    .o_sync_pin_a_oe(aoe), .o_sync_pin_b_out(bo), .o_sync_pin_b_oe(boe),
    .o_sample_tick(st), .o_exp_tick(et));
  osp_far_side osp_far_side_inst (.i_a_out(ao), .i_a_oe(aoe),
    .i_b_out(bo), .i_b_oe(boe), .i_trig(trig), .i_lf(lf), .o_a(pa), .o_b(pb));
  initial forever #5 clk = ~clk;
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(string nm, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bounded wait for a timing tick
  task automatic wt(string nm, bit x);
    int i;
    for (i = 0; i < 12 && (x ? et : st) !== 1'b1; i++) cyc(1);
    chk(nm, 1, x ? et : st);
    if (i == 12) print_verdict;
  endtask
  task automatic t_m4;
    md = OSP_MODE_SAMPLE_OUT; en = 3'h2; cyc(2);
    chk("b_oe", 1, boe); chk("b_out", 1, bo);
    ac = 3'h2; cyc(2); chk("b_out", 0, bo);
    ist = 1; cyc(1); ist = 0; chk("st", 1, st);
    cyc(1); chk("a_out", 1, ao); chk("a_oe", 1, aoe);
    iet = 1; cyc(1); iet = 0; chk("et", 1, et);
    en = 0; ac = 0; cyc(12); chk("b_oe", 0, boe);
  endtask
  task automatic t_m5;
    md = OSP_MODE_SAMPLE_RTC; cyc(2);
    chk("b_oe", 0, boe); chk("a_oe", 1, aoe);
    ist = 1; cyc(1); ist = 0; cyc(1); chk("a_out", 1, ao);
    repeat (2) begin
      lf = 0; cyc(4); lf = 1; wt("lf_tick", 1);
    end
  endtask
  task automatic t_m6;
    md = OSP_MODE_SLAVE_EXP; en = 3'h4; cyc(2);
    chk("a_oe", 0, aoe); chk("b_out", 0, bo);
    ac = 3'h4; cyc(2); chk("b_out", 1, bo);
    trig = 1; cyc(2); trig = 0; wt("trig_st", 0);
    chk("trig_et", 1, et);
    iet = 1; cyc(1); iet = 0; chk("et_off", 0, et);
    en = 0; ac = 0; cyc(2); chk("b_oe", 0, boe);
  endtask
  task automatic t_m7;
    md = OSP_MODE_MASTER_EXP; en = 3'h1; ac = 3'h1; cyc(2);
    chk("b_out", 1, bo); chk("a_oe", 1, aoe);
    iet = 1; cyc(1); iet = 0; chk("et", 1, et);
    cyc(1); chk("a_out", 1, ao);
    ist = 1; cyc(1); ist = 0; chk("st", 1, st);
    md = 4'h8; cyc(12); chk("a_oe", 0, aoe); chk("b_oe", 0, boe);
  endtask
  initial begin
    cyc(5); rb = 1; cyc(1);
    chk("a_oe", 0, aoe); chk("b_oe", 0, boe);
    t_m4; t_m5; t_m6; t_m7;
    print_verdict;
  end
endmodule // osp_sync_pins_tb_top
`default_nettype wire
